// ==== rtl/mcfp_pkg.sv ====
// shared constants and types for the monitor configuration and fan period block
package mcfp_pkg;

   // register offsets
   localparam logic [7:0] CFG_OFFSET     = 8'h03;
   localparam logic [7:0] ONESHOT_OFFSET = 8'h0f;
   localparam logic [7:0] PER_LO_OFFSET  = 8'h46;
   localparam logic [7:0] PER_HI_OFFSET  = 8'h47;
   localparam logic [7:0] CRIT_OFFSET    = 8'h20;

   // configuration field positions
   localparam int unsigned ALERT_MASK_POS   = 7;
   localparam int unsigned LOW_POWER_POS    = 6;
   localparam int unsigned DRIVE_OFF_POS    = 5;
   localparam int unsigned SPEED_EN_POS     = 2;
   localparam int unsigned CRIT_UNLOCK_POS  = 1;
   localparam int unsigned PERSIST_POS      = 0;

   // writable bits of the configuration register, 4:3 stay zero
   localparam logic [7:0] CFG_WR_MASK    = 8'he7;

   // values after reset
   localparam logic [7:0] CFG_RESET      = 8'h00;
   localparam logic [7:0] CRIT_RESET     = 8'h6e;
   localparam logic [1:0] EDGE_RESET     = 2'h0;
   localparam logic [7:0] READ_ZERO      = 8'h00;

   // fan period count and faults needed for a persistent alert
   localparam int unsigned PERIOD_W      = 14;
   localparam logic [13:0] PERIOD_MAX    = 14'h3fff;
   localparam logic [1:0] FAULT_NEED     = 2'h3;

   // measurement time base: 90 kHz tick from the 100 MHz clock
   localparam int unsigned CLK_HZ        = 100_000_000;
   localparam int unsigned TICK_HZ       = 90_000;
   localparam int unsigned TICK_DIV      = CLK_HZ / TICK_HZ;

   typedef enum logic [1:0] {
      MCFP_EDGE_RSVD  = 2'h0,
      MCFP_EDGE_TWO   = 2'h1,
      MCFP_EDGE_THREE = 2'h2,
      MCFP_EDGE_FIVE  = 2'h3
   } mcfp_edge_e;

   typedef enum logic [1:0] {
      MCFP_CONV_IDLE  = 2'h0,
      MCFP_CONV_START = 2'h1,
      MCFP_CONV_WAIT  = 2'h3
   } mcfp_conv_e;

endpackage

// ==== rtl/mcfp_tach.sv ====
// fan pulse period measurement over a selected number of edges
`timescale 1ns/10ps
module mcfp_tach #(
   parameter int unsigned PERIOD_W = 14,
   parameter int unsigned DIV_W    = 16,
   parameter int unsigned TICK_DIV = mcfp_pkg::TICK_DIV
) (
   input  wire logic                clk,        // system clock
   input  wire logic                rst,        // async reset, high
   input  wire logic                clk_en,     // freezes state when low
   input  wire logic                enable,     // speed input enable
   input  wire logic                tach_sync,  // synchronised pulse input
   input  wire logic [1:0]          edge_sel,   // edges per measurement
   input  wire logic                scale_one,  // force multiple of one
   output logic      [PERIOD_W-1:0] period     // last measured count
);
   localparam logic [PERIOD_W-1:0] MAX_CNT  = {PERIOD_W{1'b1}};
   localparam logic [DIV_W-1:0]    DIV_LAST = DIV_W'(TICK_DIV - 1);

   logic [DIV_W-1:0]    div_q,    div_d;
   logic [PERIOD_W-1:0] meas_q,   meas_d;
   logic [PERIOD_W-1:0] period_q, period_d;
   logic [2:0]          edges_q,  edges_d;
   logic                prev_q,   prev_d;
   logic                armed_q,  armed_d;
   logic [2:0]          need;
   logic [1:0]          shift;
   logic [PERIOD_W+1:0] scaled;
   logic                rise;
   logic                tick;

   always_comb begin
      case (mcfp_pkg::mcfp_edge_e'(edge_sel))
         mcfp_pkg::MCFP_EDGE_THREE: begin
            need  = 3'h3;
            shift = 2'h1;
         end
         mcfp_pkg::MCFP_EDGE_FIVE: begin
            need  = 3'h5;
            shift = 2'h0;
         end
         default: begin
            // the reserved code is measured as two edges rather than left undefined
            need  = 3'h2;
            shift = 2'h2;
         end
      endcase
      if (scale_one) begin
         shift = 2'h0;
      end
      scaled = {2'h0, meas_q} << shift;
   end

   always_comb begin
      rise     = tach_sync & ~prev_q;
      tick     = (div_q == DIV_LAST);
      prev_d   = tach_sync;
      div_d    = tick ? '0 : div_q + DIV_W'(1);
      meas_d   = meas_q;
      edges_d  = edges_q;
      armed_d  = armed_q;
      period_d = period_q;
      if (!enable) begin
         armed_d = 1'b0;
         edges_d = 3'h0;
         meas_d  = '0;
         div_d   = '0;
      end else if (rise) begin
         if (!armed_q) begin
            armed_d = 1'b1;
            edges_d = 3'h1;
            meas_d  = '0;
         end else if (edges_q + 3'h1 >= need) begin
            // closing edge opens the next window, so updates run back to back
            period_d = (scaled > {2'h0, MAX_CNT}) ? MAX_CNT : scaled[PERIOD_W-1:0];
            edges_d  = 3'h1;
            meas_d   = '0;
         end else begin
            edges_d = edges_q + 3'h1;
         end
      end else if (armed_q && tick) begin
         if (meas_q == MAX_CNT) begin
            period_d = MAX_CNT;
         end else begin
            meas_d = meas_q + PERIOD_W'(1);
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         div_q    <= '0;
         meas_q   <= '0;
         period_q <= MAX_CNT;
         edges_q  <= 3'h0;
         prev_q   <= 1'b0;
         armed_q  <= 1'b0;
      end else if (clk_en) begin
         div_q    <= div_d;
         meas_q   <= meas_d;
         period_q <= period_d;
         edges_q  <= edges_d;
         prev_q   <= prev_d;
         armed_q  <= armed_d;
      end
   end

   assign period = period_q;

endmodule // mcfp_tach

// ==== rtl/mcfp_top.sv ====
// configuration register, conversion control, alert queue and fan period registers
`timescale 1ns/10ps
module mcfp_top #(
   parameter int unsigned PERIOD_W = mcfp_pkg::PERIOD_W,
   parameter int unsigned TICK_DIV = mcfp_pkg::TICK_DIV
) (
   input  wire logic       clk,            // 100 MHz system clock
   input  wire logic       rst,            // async reset, high
   input  wire logic       clk_en,         // freezes all state when low
   input  wire logic [7:0] reg_addr,       // register offset
   input  wire logic       reg_wr,         // write strobe, one cycle
   input  wire logic       reg_rd,         // read strobe, one cycle
   input  wire logic [7:0] reg_wdata,      // write data
   output logic      [7:0] reg_rdata,      // read data, valid cycle after reg_rd
   input  wire logic       tach_pin,       // fan pulse pin, asynchronous
   input  wire logic       pwm_clk_360k,   // pwm clock choice is 360 kHz
   input  wire logic       pwm_polarity,   // pwm disabled level
   input  wire logic       pwm_wave,       // fan control waveform from pwm generator
   output logic            pwm_out,        // pwm output level
   output logic            conv_start,     // one-cycle conversion start pulse
   input  wire logic       conv_done,      // one-cycle end of conversion
   input  wire logic       remote_fault,   // remote result beyond high or low setpoint
   input  wire logic       alert_clear,    // clears the latched alert
   output logic            alert_pin_out,  // alert pin drive level, always low
   output logic            alert_pin_oe,   // alert pin pulled low while high
   output logic      [7:0] crit_limit      // remote critical temperature limit
);

   // register bus decode
   logic wr_cfg;
   logic wr_oneshot;
   logic wr_lo;
   logic wr_crit;
   logic rd_lo;
   logic rd_hi;

   assign wr_cfg     = reg_wr && (reg_addr == mcfp_pkg::CFG_OFFSET);
   assign wr_oneshot = reg_wr && (reg_addr == mcfp_pkg::ONESHOT_OFFSET);
   assign wr_lo      = reg_wr && (reg_addr == mcfp_pkg::PER_LO_OFFSET);
   assign wr_crit    = reg_wr && (reg_addr == mcfp_pkg::CRIT_OFFSET);
   assign rd_lo      = reg_rd && (reg_addr == mcfp_pkg::PER_LO_OFFSET);
   assign rd_hi      = reg_rd && (reg_addr == mcfp_pkg::PER_HI_OFFSET);

   // configuration, edge select and critical limit
   logic [7:0] cfg_q,  cfg_d;
   logic [1:0] edge_q, edge_d;
   logic [7:0] crit_q, crit_d;

   logic alert_mask;
   logic low_power;
   logic drive_off;
   logic speed_en;
   logic crit_unlock;
   logic persist;

   assign alert_mask  = cfg_q[mcfp_pkg::ALERT_MASK_POS];
   assign low_power   = cfg_q[mcfp_pkg::LOW_POWER_POS];
   assign drive_off   = cfg_q[mcfp_pkg::DRIVE_OFF_POS];
   assign speed_en    = cfg_q[mcfp_pkg::SPEED_EN_POS];
   assign crit_unlock = cfg_q[mcfp_pkg::CRIT_UNLOCK_POS];
   assign persist     = cfg_q[mcfp_pkg::PERSIST_POS];

   always_comb begin
      cfg_d  = cfg_q;
      edge_d = edge_q;
      crit_d = crit_q;
      if (wr_cfg) begin
         cfg_d = reg_wdata & mcfp_pkg::CFG_WR_MASK;
      end
      if (wr_lo) begin
         // software is expected to keep away from the reserved code
         edge_d = reg_wdata[1:0];
      end
      if (wr_crit && crit_unlock) begin
         crit_d = reg_wdata;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg_q  <= mcfp_pkg::CFG_RESET;
         edge_q <= mcfp_pkg::EDGE_RESET;
         crit_q <= mcfp_pkg::CRIT_RESET;
      end else if (clk_en) begin
         cfg_q  <= cfg_d;
         edge_q <= edge_d;
         crit_q <= crit_d;
      end
   end

   assign crit_limit = crit_q;

   // conversion sequencer
   mcfp_pkg::mcfp_conv_e conv_q, conv_d;
   logic oneshot_q,  oneshot_d;
   logic start_q,    start_d;
   logic take;

   always_comb begin
      conv_d = conv_q;
      take   = 1'b0;
      case (conv_q)
         mcfp_pkg::MCFP_CONV_IDLE: begin
            if (!low_power || oneshot_q) begin
               conv_d = mcfp_pkg::MCFP_CONV_START;
               take   = oneshot_q;
            end
         end
         mcfp_pkg::MCFP_CONV_START: begin
            conv_d = mcfp_pkg::MCFP_CONV_WAIT;
         end
         mcfp_pkg::MCFP_CONV_WAIT: begin
            // a conversion in flight is finished even if standby is entered
            if (conv_done) begin
               conv_d = mcfp_pkg::MCFP_CONV_IDLE;
            end
         end
         default: begin
            conv_d = mcfp_pkg::MCFP_CONV_IDLE;
         end
      endcase
      // a new one-shot write wins over the clear of the pending request
      oneshot_d = (wr_oneshot && low_power) || (oneshot_q && !take && low_power);
      start_d   = (conv_d == mcfp_pkg::MCFP_CONV_START);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         conv_q    <= mcfp_pkg::MCFP_CONV_IDLE;
         oneshot_q <= 1'b0;
         start_q   <= 1'b0;
      end else if (clk_en) begin
         conv_q    <= conv_d;
         oneshot_q <= oneshot_d;
         start_q   <= start_d;
      end
   end

   assign conv_start = start_q;

   // remote fault queue and alert
   logic [1:0] fault_q, fault_d;
   logic       alert_q, alert_d;
   logic       oe_q,    oe_d;
   logic       fire;
   logic       result;

   always_comb begin
      result  = conv_done && (conv_q == mcfp_pkg::MCFP_CONV_WAIT);
      fault_d = fault_q;
      fire    = 1'b0;
      if (result) begin
         if (remote_fault) begin
            if (fault_q != mcfp_pkg::FAULT_NEED) begin
               fault_d = fault_q + 2'h1;
            end
            if (persist) begin
               fire = (fault_d == mcfp_pkg::FAULT_NEED);
            end else begin
               fire = 1'b1;
            end
         end else begin
            fault_d = 2'h0;
         end
      end
      // an alert event in the clearing cycle stays latched
      alert_d = fire || (alert_q && !alert_clear);
      oe_d    = alert_d && !alert_mask;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fault_q <= 2'h0;
         alert_q <= 1'b0;
         oe_q    <= 1'b0;
      end else if (clk_en) begin
         fault_q <= fault_d;
         alert_q <= alert_d;
         oe_q    <= oe_d;
      end
   end

   assign alert_pin_oe  = oe_q;
   assign alert_pin_out = 1'b0;

   // pwm output gating
   logic pwm_q, pwm_d;

   always_comb begin
      if (low_power && drive_off) begin
         pwm_d = pwm_polarity;
      end else begin
         pwm_d = pwm_wave;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pwm_q <= 1'b0;
      end else if (clk_en) begin
         pwm_q <= pwm_d;
      end
   end

   assign pwm_out = pwm_q;

   // fan pulse synchroniser and period measurement
   logic                tach_s1_q;
   logic                tach_s2_q;
   logic [PERIOD_W-1:0] period;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tach_s1_q <= 1'b0;
         tach_s2_q <= 1'b0;
      end else if (clk_en) begin
         tach_s1_q <= tach_pin;
         tach_s2_q <= tach_s1_q;
      end
   end

   mcfp_tach #(
      .PERIOD_W (PERIOD_W),
      .DIV_W    (16),
      .TICK_DIV (TICK_DIV)
   ) u_tach (
      .clk       (clk),
      .rst       (rst),
      .clk_en    (clk_en),
      .enable    (speed_en),
      .tach_sync (tach_s2_q),
      .edge_sel  (edge_q),
      .scale_one (pwm_clk_360k),
      .period    (period)
   );

   // period read lock and read data
   logic [7:0] hold_q,  hold_d;
   logic       lock_q,  lock_d;
   logic [7:0] rdata_q, rdata_d;

   always_comb begin
      hold_d  = hold_q;
      lock_d  = lock_q;
      rdata_d = rdata_q;
      if (rd_lo) begin
         hold_d = period[PERIOD_W-1:PERIOD_W-8];
         lock_d = 1'b1;
      end else if (rd_hi) begin
         lock_d = 1'b0;
      end
      if (reg_rd) begin
         case (reg_addr)
            mcfp_pkg::CFG_OFFSET: begin
               rdata_d = cfg_q & mcfp_pkg::CFG_WR_MASK;
            end
            mcfp_pkg::PER_LO_OFFSET: begin
               rdata_d = {period[5:0], edge_q};
            end
            mcfp_pkg::PER_HI_OFFSET: begin
               // without a preceding low read the live count is returned
               rdata_d = lock_q ? hold_q : period[PERIOD_W-1:PERIOD_W-8];
            end
            mcfp_pkg::CRIT_OFFSET: begin
               rdata_d = crit_q;
            end
            default: begin
               rdata_d = mcfp_pkg::READ_ZERO;
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hold_q  <= mcfp_pkg::READ_ZERO;
         lock_q  <= 1'b0;
         rdata_q <= mcfp_pkg::READ_ZERO;
      end else if (clk_en) begin
         hold_q  <= hold_d;
         lock_q  <= lock_d;
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;

endmodule // mcfp_top

// ==== testbench/mcfp_monitor.sv ====
// assertion checker bound to the monitor configuration and fan period block
`timescale 1ns/10ps
module mcfp_monitor (
   input wire logic       clk,           // clock
   input wire logic       rst,           // reset
   input wire logic [7:0] reg_addr,      // offset
   input wire logic       reg_wr,        // write strobe
   input wire logic       reg_rd,        // read strobe
   input wire logic [7:0] reg_wdata,     // write data
   input wire logic [7:0] reg_rdata,     // read data
   input wire logic       pwm_polarity,  // disabled level
   input wire logic       pwm_wave,      // waveform in
   input wire logic       pwm_out,       // pwm out
   input wire logic       conv_start,    // start pulse
   input wire logic       conv_done,     // end pulse
   input wire logic       remote_fault,  // fault level
   input wire logic       alert_pin_out, // pin level
   input wire logic       alert_pin_oe,  // pin enable
   input wire logic [7:0] crit_limit     // critical limit
);
   logic [7:0] cfg_q, cfg_d;
   logic       shot_q, shot_d, known_q, known_d;
   logic [1:0] cnt_q, cnt_d;

   // fault run length is only trusted after a clean result seen with persistence on
   always_comb begin
      cfg_d = cfg_q;
      shot_d = shot_q;
      known_d = known_q;
      cnt_d = cnt_q;
      if (reg_wr && reg_addr == mcfp_pkg::CFG_OFFSET) cfg_d = reg_wdata & mcfp_pkg::CFG_WR_MASK;
      if (conv_start || !cfg_q[6]) shot_d = 1'b0;
      if (reg_wr && reg_addr == mcfp_pkg::ONESHOT_OFFSET && cfg_q[6]) shot_d = 1'b1;
      if (!cfg_q[0]) begin
         known_d = 1'b0;
         cnt_d = 2'h0;
      end else if (conv_done && !remote_fault) begin
         known_d = 1'b1;
         cnt_d = 2'h0;
      end else if (conv_done && cnt_q != 2'h3) begin
         cnt_d = cnt_q + 2'h1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg_q <= 8'h00;
         shot_q <= 1'b0;
         known_q <= 1'b0;
         cnt_q <= 2'h0;
      end else begin
         cfg_q <= cfg_d;
         shot_q <= shot_d;
         known_q <= known_d;
         cnt_q <= cnt_d;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   a_alert_pin_low: assert property (alert_pin_out == 1'b0)
      else $error("alert drive level not low");
   a_mask_keeps_open: assert property (cfg_q[7] && $past(cfg_q[7]) |-> !alert_pin_oe)
      else $error("alert pin pulled while masked");
   a_pwm_follows: assert property
      (!$past(rst) && !$past(cfg_q[6] && cfg_q[5]) |-> pwm_out == $past(pwm_wave))
      else $error("pwm output not following waveform");
   a_pwm_off_hold: assert property
      (!$past(rst) && $past(cfg_q[6] && cfg_q[5]) |-> pwm_out == $past(pwm_polarity))
      else $error("pwm output not at disabled level");
   a_no_start_hold: assert property (conv_start |-> !$past(cfg_q[6]) || $past(shot_q))
      else $error("conversion started in standby");
   a_alert_single: assert property (conv_done && remote_fault && !cfg_q[0] && !cfg_q[7] |=> alert_pin_oe)
      else $error("single fault gave no alert");
   a_queue_holds: assert property
      (known_q && conv_done && remote_fault && cfg_q[0] && cnt_q < 2'h2 && !cfg_q[7] && $stable(cfg_q[7])
       && !alert_pin_oe |=> !alert_pin_oe)
      else $error("alert before three faults");
   a_crit_locked: assert property
      (reg_wr && reg_addr == mcfp_pkg::CRIT_OFFSET && !cfg_q[1] |=> $stable(crit_limit))
      else $error("locked limit changed");
   a_crit_write: assert property
      (reg_wr && reg_addr == mcfp_pkg::CRIT_OFFSET && cfg_q[1] |=> crit_limit == $past(reg_wdata))
      else $error("unlocked limit not written");
   a_cfg_readback: assert property (reg_rd && reg_addr == mcfp_pkg::CFG_OFFSET |=> reg_rdata == cfg_q)
      else $error("configuration read wrong");
endmodule // mcfp_monitor

bind mcfp_top mcfp_monitor u_mon (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pwm_polarity(pwm_polarity), .pwm_wave(pwm_wave),
   .pwm_out(pwm_out), .conv_start(conv_start), .conv_done(conv_done), .remote_fault(remote_fault),
   .alert_pin_out(alert_pin_out), .alert_pin_oe(alert_pin_oe), .crit_limit(crit_limit));

// ==== testbench/mcfp_far_model.sv ====
// behavioural converter and pulse-output fan facing the block
`timescale 1ns/10ps
module mcfp_far_model (
   input  wire logic       clk,          // clock
   input  wire logic       rst,          // reset
   input  wire logic       conv_start,   // start from block
   input  wire logic       fault_in,     // result to report
   input  wire logic [7:0] conv_wait,    // extra conversion cycles
   input  wire logic [9:0] fan_half,     // half fan period, 0 stops the fan
   output logic            conv_done,    // end of conversion
   output logic            remote_fault, // result, valid with conv_done
   output logic            tach_pin      // fan pulses
);
   logic       busy_q;
   logic [7:0] left_q;
   logic [9:0] fan_cnt_q;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         busy_q <= 1'b0;
         left_q <= 8'h00;
         conv_done <= 1'b0;
         fan_cnt_q <= 10'h000;
         tach_pin <= 1'b0;
      end else begin
         conv_done <= busy_q && left_q == 8'h00;
         if (conv_start) begin
            busy_q <= 1'b1;
            left_q <= conv_wait;
         end else if (busy_q && left_q == 8'h00) begin
            busy_q <= 1'b0;
         end else if (busy_q) begin
            left_q <= left_q - 8'h01;
         end
         fan_cnt_q <= (fan_cnt_q + 10'h001 >= fan_half) ? 10'h000 : fan_cnt_q + 10'h001;
         if (fan_half != 10'h000 && fan_cnt_q + 10'h001 >= fan_half) tach_pin <= !tach_pin;
      end
   end

   // outside the done cycle the line shows the opposite value, so a stale sample is caught
   assign remote_fault = conv_done ? fault_in : !fault_in;
endmodule // mcfp_far_model

// ==== testbench/mcfp_tb_top.sv ====
// self-checking testbench for the monitor configuration and fan period block
`timescale 1ns/10ps
module mcfp_tb_top;
   typedef struct packed {
      logic [1:0]  esel;
      logic        fast;
      logic [13:0] per;
      logic [3:0]  mult;
   } mcfp_row_s;
   localparam mcfp_row_s ROWS [6] = '{'{2'h1, 1'b0, 14'h0c8, 4'h4}, '{2'h2, 1'b0, 14'h0c8, 4'h2},
      '{2'h3, 1'b0, 14'h0c8, 4'h1}, '{2'h1, 1'b1, 14'h032, 4'h1}, '{2'h2, 1'b1, 14'h064, 4'h1},
      '{2'h3, 1'b1, 14'h0c8, 4'h1}};

   logic        clk, rst, reg_wr, reg_rd, pwm_clk_360k, pwm_polarity, pwm_wave, alert_clear, fault_in;
   logic        tach_pin, pwm_out, conv_start, conv_done, remote_fault, alert_pin_out, alert_pin_oe;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, crit_limit, conv_wait, lo, hi;
   logic [9:0]  fan_half;
   int          fails = 0, checks = 0, cycles = 0, n;

   mcfp_top #(.TICK_DIV(4)) uut (.clk(clk), .rst(rst), .clk_en(1'b1), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .tach_pin(tach_pin),
      .pwm_clk_360k(pwm_clk_360k), .pwm_polarity(pwm_polarity), .pwm_wave(pwm_wave), .pwm_out(pwm_out),
      .conv_start(conv_start), .conv_done(conv_done), .remote_fault(remote_fault), .alert_clear(alert_clear),
      .alert_pin_out(alert_pin_out), .alert_pin_oe(alert_pin_oe), .crit_limit(crit_limit));
   mcfp_far_model u_far (.clk(clk), .rst(rst), .conv_start(conv_start), .fault_in(fault_in),
      .conv_wait(conv_wait), .fan_half(fan_half), .conv_done(conv_done), .remote_fault(remote_fault),
      .tach_pin(tach_pin));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk) begin
      pwm_wave <= rst ? 1'b0 : !pwm_wave;
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         fails = fails + 1;
         complete_run();
      end
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks = checks + 1;
      if (seen !== exp) begin
         fails = fails + 1;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic complete_run();
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic tick(input int len);
      repeat (len) @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      d = reg_rdata;
   endtask

   task automatic count_starts(input int len);
      n = 0;
      repeat (len) begin
         @(posedge clk);
         if (conv_start === 1'b1) n++;
      end
   endtask

   // returns one edge after the done pulse so the alert register has settled
   task automatic wait_done();
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (conv_done !== 1'b1 && n < 200);
      @(posedge clk);
   endtask

   // the measurement window starts on an arbitrary tick phase, so allow two ticks of slack
   function automatic logic in_band(logic [13:0] p, logic [13:0] e, logic [3:0] m);
      return (p + {9'h000, m, 1'b0} >= e) && (p <= e + {9'h000, m, 1'b0});
   endfunction

   initial begin
      rst = 1'b1;
      {reg_wr, reg_rd, pwm_clk_360k, pwm_polarity, pwm_wave, alert_clear, fault_in} = 7'h00;
      {reg_addr, reg_wdata} = 16'h0000;
      conv_wait = 8'h0a;
      fan_half = 10'h064;
      tick(8);
      rst <= 1'b0;
      wr(mcfp_pkg::CFG_OFFSET, 8'h04);
      foreach (ROWS[i]) begin
         pwm_clk_360k <= ROWS[i].fast;
         wr(mcfp_pkg::PER_LO_OFFSET, {6'h00, ROWS[i].esel});
         tick(2500);
         rd(mcfp_pkg::PER_LO_OFFSET, lo);
         rd(mcfp_pkg::PER_HI_OFFSET, hi);
         check({6'h00, lo[1:0]}, {6'h00, ROWS[i].esel});
         check({7'h00, in_band({hi, lo[7:2]}, ROWS[i].per, ROWS[i].mult)}, 8'h01);
      end
      rd(mcfp_pkg::PER_LO_OFFSET, lo);
      fan_half <= 10'h12c;
      tick(6000);
      rd(mcfp_pkg::PER_HI_OFFSET, hi);
      check(hi, 8'h03);
      rd(mcfp_pkg::PER_HI_OFFSET, hi);
      check(hi, 8'h09);
      wr(mcfp_pkg::CFG_OFFSET, 8'h00);
      fan_half <= 10'h064;
      tick(3000);
      rd(mcfp_pkg::PER_HI_OFFSET, hi);
      check(hi, 8'h09);
      wr(mcfp_pkg::CRIT_OFFSET, 8'h55);
      tick(1);
      check(crit_limit, mcfp_pkg::CRIT_RESET);
      wr(mcfp_pkg::CFG_OFFSET, 8'h02);
      wr(mcfp_pkg::CRIT_OFFSET, 8'h55);
      tick(1);
      check(crit_limit, 8'h55);
      wr(mcfp_pkg::CRIT_OFFSET, 8'h33);
      tick(1);
      check(crit_limit, 8'h33);
      wr(mcfp_pkg::CFG_OFFSET, 8'hff);
      rd(mcfp_pkg::CFG_OFFSET, lo);
      check(lo, 8'he7);
      rd(8'h10, lo);
      check(lo, 8'h00);
      wr(mcfp_pkg::CFG_OFFSET, 8'h40);
      tick(40);
      // the waveform toggles every cycle, so the output lags it by one and reads as its inverse
      check({7'h00, pwm_out}, {7'h00, !pwm_wave});
      count_starts(200);
      check(8'(n), 8'h00);
      wr(mcfp_pkg::ONESHOT_OFFSET, 8'ha5);
      count_starts(100);
      check(8'(n), 8'h01);
      wr(mcfp_pkg::CFG_OFFSET, 8'h60);
      pwm_polarity <= 1'b1;
      tick(3);
      check({7'h00, pwm_out}, 8'h01);
      tick(1);
      check({7'h00, pwm_out}, 8'h01);
      pwm_polarity <= 1'b0;
      tick(3);
      check({7'h00, pwm_out}, 8'h00);
      tick(1);
      check({7'h00, pwm_out}, 8'h00);
      conv_wait <= 8'h00;
      fault_in <= 1'b1;
      wr(mcfp_pkg::CFG_OFFSET, 8'h00);
      wait_done();
      wait_done();
      check({7'h00, alert_pin_oe}, 8'h01);
      wr(mcfp_pkg::CFG_OFFSET, 8'h80);
      tick(3);
      check({7'h00, alert_pin_oe}, 8'h00);
      wr(mcfp_pkg::CFG_OFFSET, 8'h01);
      fault_in <= 1'b0;
      wait_done();
      wait_done();
      alert_clear <= 1'b1;
      tick(1);
      alert_clear <= 1'b0;
      fault_in <= 1'b1;
      for (int k = 1; k <= 3; k++) begin
         wait_done();
         check({7'h00, alert_pin_oe}, {7'h00, k == 3});
      end
      rst <= 1'b1;
      tick(2);
      rst <= 1'b0;
      check(crit_limit, 8'h6e);
      rd(mcfp_pkg::CFG_OFFSET, lo);
      check(lo, 8'h00);
      rd(mcfp_pkg::PER_LO_OFFSET, lo);
      rd(mcfp_pkg::PER_HI_OFFSET, hi);
      check(lo, 8'hfc);
      check(hi, 8'hff);
      complete_run();
   end
endmodule // mcfp_tb_top
